/* File: vout_setpoint_defines.vh */
// Command codes, field layout, reset values and range constants for the setpoint logic
`ifndef VOUT_SETPOINT_DEFINES_VH
`define VOUT_SETPOINT_DEFINES_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_OUTPUT_FORMAT_MODE 8'h20
`define CMD_OUTPUT_VOLTAGE_SETPOINT 8'h21
`define CMD_OUTPUT_VOLTAGE_OFFSET 8'h22

// ----------------------------------------
// Format mode fields
// ----------------------------------------
`define MODE_REL_BIT 7
`define MODE_KIND_HI 6
`define MODE_KIND_LO 5
`define MODE_KIND_LINEAR 2'b00
`define MODE_EXP_HI 4
`define MODE_EXP_LO 0
`define MODE_EXP_MIN 5'h14
`define MODE_EXP_MAX 5'h1C
`define MODE_RESET 8'h14
`define EXP_SHIFT_BIAS 4'h4

// ----------------------------------------
// Internal scale and ranges (units of 2^-12 V)
// ----------------------------------------
`define COMMON_W 26
`define SUM_W 27
`define RANGE_SCALE_1000 16'h0B33
`define RANGE_SCALE_0500 16'h1666
`define RANGE_SCALE_0250 16'h2CCC
`define RANGE_SCALE_0125 16'h6000
`define SCALE_SEL_1000 2'b00
`define SCALE_SEL_0500 2'b01
`define SCALE_SEL_0250 2'b10
`define SCALE_SEL_0125 2'b11
`define TRIM_BACKUP_MAX 8'h7F
`define TRIM_BACKUP_MIN 8'h80

`endif

/* File: setpoint_clamp.v */
// Limit and DAC-range clamp of the combined setpoint
`timescale 1ns/1ps
module setpoint_clamp (
  input wire signed [26:0] setpoint_sum,
  input wire [15:0] vout_upper_limit,
  input wire [15:0] vout_lower_limit,
  input wire [1:0] scale_loop_sel,
  output reg [15:0] dac_ceiling,
  output reg [15:0] dac_target,
  output reg limit_violation
);

`include "vout_setpoint_defines.vh"

  // ----------------------------------------
  // Range ceiling per loop scale
  // ----------------------------------------
  always @* begin
    case (scale_loop_sel)
      `SCALE_SEL_1000: dac_ceiling = `RANGE_SCALE_1000;
      `SCALE_SEL_0500: dac_ceiling = `RANGE_SCALE_0500;
      `SCALE_SEL_0250: dac_ceiling = `RANGE_SCALE_0250;
      default: dac_ceiling = `RANGE_SCALE_0125;
    endcase
  end

  // Limits first with warning, then silent DAC clamp
  always @* begin
    limit_violation = 1'b0;
    if (setpoint_sum > $signed({11'd0, vout_upper_limit})) begin
      limit_violation = 1'b1;
      dac_target = vout_upper_limit;
    end else if (setpoint_sum < $signed({11'd0, vout_lower_limit})) begin
      limit_violation = 1'b1;
      dac_target = vout_lower_limit;
    end else if (setpoint_sum < 27'sd0) begin
      dac_target = 16'h0000;
    end else begin
      dac_target = setpoint_sum[15:0];
    end
    // Ceiling beyond the limits still clamps, with no warning
    if (dac_target > dac_ceiling) begin
      dac_target = dac_ceiling;
    end
  end

endmodule

/* File: setpoint_slew.v */
// Reference ramp that walks the DAC code toward its target at a fixed step per clock
`timescale 1ns/1ps
module setpoint_slew (
  input wire clk,
  input wire reset_n,
  input wire [15:0] ramp_target,
  input wire [15:0] ramp_step,
  output reg [15:0] ramp_level_r,
  output wire ramp_settled
);

  reg [15:0] ramp_level_nxt;

  assign ramp_settled = (ramp_level_r == ramp_target);

  // ----------------------------------------
  // Step toward target; zero step jumps at once
  // ----------------------------------------
  always @* begin
    ramp_level_nxt = ramp_level_r;
    if (ramp_step == 16'h0000) begin
      ramp_level_nxt = ramp_target;
    end else if (ramp_level_r < ramp_target) begin
      if (ramp_target - ramp_level_r > ramp_step) begin
        ramp_level_nxt = ramp_level_r + ramp_step;
      end else begin
        ramp_level_nxt = ramp_target;
      end
    end else if (ramp_level_r > ramp_target) begin
      if (ramp_level_r - ramp_target > ramp_step) begin
        ramp_level_nxt = ramp_level_r - ramp_step;
      end else begin
        ramp_level_nxt = ramp_target;
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ramp_level_r <= 16'h0000;
    end else begin
      ramp_level_r <= ramp_level_nxt;
    end
  end

endmodule

/* File: vout_setpoint_command_logic.v */
// Output-voltage setpoint command registers, boot defaults, clamping and ramp control
`timescale 1ns/1ps
module vout_setpoint_command_logic (
  input wire clk,
  input wire reset_n,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  output reg [15:0] cmd_rdata_r,
  output reg cmd_rvalid_r,
  output reg invalid_data_r,
  output reg max_min_warning_r,
  input wire conversion_enabled,
  input wire restore_user_all,
  input wire [7:0] nvm_format_mode,
  input wire [15:0] nvm_setpoint_default,
  input wire [7:0] nvm_offset_backup,
  input wire strap_override_word,
  input wire [15:0] voltage_strap_pin,
  input wire reset_pin_enable,
  input wire powergood_reset_pin_n,
  input wire fault_shutdown,
  input wire fault_reload_select,
  input wire [15:0] vout_upper_limit,
  input wire [15:0] vout_lower_limit,
  input wire [1:0] scale_loop_sel,
  input wire [15:0] transition_step,
  output reg [7:0] offset_backup_r,
  output wire [15:0] dac_reference,
  output wire reference_settled,
  output wire relative_format_flag
);

`include "vout_setpoint_defines.vh"

  // ----------------------------------------
  // Boot sequencer states
  // ----------------------------------------
  localparam [1:0] ST_LOAD = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg rel_flag_r;
  reg [4:0] exponent_r;
  reg signed [25:0] setpoint_r;
  reg signed [25:0] offset_r;
  reg signed [25:0] boot_default_voltage_r;
  reg write_event_r;

  wire write_hit = cmd_valid & cmd_write;
  wire read_hit = cmd_valid & ~cmd_write;
  wire boot_load = (state_r == ST_LOAD) | restore_user_all;
  wire [15:0] dac_ceiling;
  wire [15:0] dac_target;
  wire limit_violation;

  assign relative_format_flag = rel_flag_r;

  // ----------------------------------------
  // Format conversion helpers
  // ----------------------------------------
  // Shift from the current exponent to the 2^-12 common scale
  function [3:0] exp_shift;
    input [4:0] e;
    begin
      exp_shift = e[3:0] - `EXP_SHIFT_BIAS;
    end
  endfunction

  function signed [25:0] to_common;
    input [15:0] v;
    input is_signed;
    input [4:0] e;
    reg signed [25:0] ext;
    begin
      ext = is_signed ? {{10{v[15]}}, v} : {10'd0, v};
      to_common = ext <<< exp_shift(e);
    end
  endfunction

  function [15:0] from_common;
    input signed [25:0] v;
    input [4:0] e;
    reg signed [25:0] sh;
    begin
      sh = v >>> exp_shift(e);
      from_common = sh[15:0];
    end
  endfunction

  function exp_supported;
    input [4:0] e;
    begin
      exp_supported = (e >= `MODE_EXP_MIN) && (e <= `MODE_EXP_MAX);
    end
  endfunction

  // Boot setpoint in common scale, from the strap word or from NVM
  function signed [25:0] boot_source;
    input use_strap;
    input [15:0] strap_value;
    input [15:0] nvm_value;
    input [4:0] nvm_exp;
    begin
      if (use_strap) begin
        boot_source = {10'd0, strap_value};
      end else begin
        boot_source = to_common(nvm_value, 1'b0, nvm_exp);
      end
    end
  endfunction

  // ----------------------------------------
  // Decode of writes
  // ----------------------------------------
  wire mode_wr = write_hit & (cmd_code == `CMD_OUTPUT_FORMAT_MODE);
  wire set_wr = write_hit & (cmd_code == `CMD_OUTPUT_VOLTAGE_SETPOINT);
  wire off_wr = write_hit & (cmd_code == `CMD_OUTPUT_VOLTAGE_OFFSET);
  wire mode_ok = (cmd_wdata[`MODE_KIND_HI:`MODE_KIND_LO] == `MODE_KIND_LINEAR)
    & exp_supported(cmd_wdata[`MODE_EXP_HI:`MODE_EXP_LO]);
  wire mode_take = mode_wr & mode_ok & ~conversion_enabled;

  // NVM exponent outside the supported span falls back to -12, never an odd shift
  wire [4:0] nvm_exp = exp_supported(nvm_format_mode[`MODE_EXP_HI:`MODE_EXP_LO]) ?
    nvm_format_mode[`MODE_EXP_HI:`MODE_EXP_LO] : `MODE_EXP_MIN;
  // One boot value, so load, restore and the stored default always agree
  wire signed [25:0] boot_value = boot_source(strap_override_word, voltage_strap_pin,
    nvm_setpoint_default, nvm_exp);
  // Write data is read with the exponent in force right now
  wire signed [25:0] set_new = to_common(cmd_wdata, 1'b0, exponent_r);
  wire signed [25:0] off_new = to_common(cmd_wdata, 1'b1, exponent_r);
  wire signed [26:0] trial_sum = {setpoint_r[25], setpoint_r} + {off_new[25], off_new};
  wire off_ok = (trial_sum >= 27'sd0) && (trial_sum <= $signed({11'd0, dac_ceiling}));
  wire off_take = off_wr & off_ok;
  wire signed [26:0] setpoint_sum = {setpoint_r[25], setpoint_r} + {offset_r[25], offset_r};

  // Offset saturated to the 8-bit backup range at exponent -12
  wire offset_hi = offset_r > $signed({{18{1'b0}}, `TRIM_BACKUP_MAX});
  wire offset_lo = offset_r < $signed({{18{1'b1}}, `TRIM_BACKUP_MIN});

  // ----------------------------------------
  // Boot sequencer
  // ----------------------------------------
  always @* begin
    case (state_r)
      ST_LOAD: state_nxt = ST_RUN;
      ST_RUN: state_nxt = ST_RUN;
      default: state_nxt = ST_LOAD;
    endcase
  end

  // Defaults are caught one edge after release, never under reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_LOAD;
      boot_default_voltage_r <= 26'sd0;
    end else begin
      state_r <= state_nxt;
      // Only load or restore refresh it; host setpoint writes never reach it
      if (boot_load) begin
        boot_default_voltage_r <= boot_value;
      end
    end
  end

  // ----------------------------------------
  // Format mode register
  // ----------------------------------------
  // Values are kept in common scale, so a new exponent re-expresses them on read
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rel_flag_r <= 1'b0;
      exponent_r <= `MODE_EXP_MIN;
    end else if (boot_load) begin
      rel_flag_r <= nvm_format_mode[`MODE_REL_BIT];
      exponent_r <= nvm_exp;
    end else if (mode_take) begin
      rel_flag_r <= cmd_wdata[`MODE_REL_BIT];
      exponent_r <= cmd_wdata[`MODE_EXP_HI:`MODE_EXP_LO];
    end
  end

  // ----------------------------------------
  // Setpoint register
  // ----------------------------------------
  // Restore and reset-pin events outrank a host write in the same cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      setpoint_r <= 26'sd0;
    end else if (state_r == ST_LOAD) begin
      setpoint_r <= boot_value;
    end else if (restore_user_all) begin
      setpoint_r <= boot_value;
    end else if (reset_pin_enable && !powergood_reset_pin_n) begin
      setpoint_r <= boot_default_voltage_r;
    end else if (fault_shutdown && fault_reload_select) begin
      setpoint_r <= boot_default_voltage_r;
    end else if (set_wr) begin
      setpoint_r <= set_new;
    end
  end

  // ----------------------------------------
  // Offset register and its byte backup
  // ----------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      offset_r <= 26'sd0;
      offset_backup_r <= 8'h00;
    end else begin
      if (boot_load) begin
        offset_r <= {{18{nvm_offset_backup[7]}}, nvm_offset_backup};
      end else if (off_take) begin
        offset_r <= off_new;
      end
      if (offset_hi) begin
        offset_backup_r <= `TRIM_BACKUP_MAX;
      end else if (offset_lo) begin
        offset_backup_r <= `TRIM_BACKUP_MIN;
      end else begin
        offset_backup_r <= offset_r[7:0];
      end
    end
  end

  // ----------------------------------------
  // Status pulses
  // ----------------------------------------
  // Warning is judged one edge after the write, on the updated sum
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_event_r <= 1'b0;
      invalid_data_r <= 1'b0;
      max_min_warning_r <= 1'b0;
    end else begin
      write_event_r <= set_wr | off_take;
      invalid_data_r <= (off_wr & ~off_ok) | (mode_wr & ~mode_ok);
      max_min_warning_r <= write_event_r & limit_violation;
    end
  end

  // ----------------------------------------
  // Read answers
  // ----------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_rdata_r <= 16'h0000;
      cmd_rvalid_r <= 1'b0;
    end else begin
      cmd_rvalid_r <= read_hit;
      if (read_hit) begin
        case (cmd_code)
          `CMD_OUTPUT_FORMAT_MODE: cmd_rdata_r <= {8'h00, rel_flag_r, `MODE_KIND_LINEAR, exponent_r};
          `CMD_OUTPUT_VOLTAGE_SETPOINT: cmd_rdata_r <= from_common(setpoint_r, exponent_r);
          `CMD_OUTPUT_VOLTAGE_OFFSET: cmd_rdata_r <= from_common(offset_r, exponent_r);
          default: cmd_rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Clamp and ramp toward the reference DAC
  // ----------------------------------------
  setpoint_clamp u_clamp (
    .setpoint_sum(setpoint_sum),
    .vout_upper_limit(vout_upper_limit),
    .vout_lower_limit(vout_lower_limit),
    .scale_loop_sel(scale_loop_sel),
    .dac_ceiling(dac_ceiling),
    .dac_target(dac_target),
    .limit_violation(limit_violation)
  );

  setpoint_slew u_slew (
    .clk(clk),
    .reset_n(reset_n),
    .ramp_target(dac_target),
    .ramp_step(transition_step),
    .ramp_level_r(dac_reference),
    .ramp_settled(reference_settled)
  );

endmodule

/* File: vout_host_model.sv */
// Command-port host model issuing one-cycle reads and writes
`timescale 1ns/1ps
module vout_host_model (
  input wire logic clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata_r,
  input wire logic cmd_rvalid_r
);
  // --------------------------------
  // Bus cycles
  // --------------------------------
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // One-cycle write; the host orders writes against the mode in force
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~data; // Stale data would hide a missing qualifier
  endtask

  // Read answer is due exactly one cycle after the taking edge
  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b0;
    cmd_code <= code;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~code;
    @(posedge clk);
    data = (cmd_rvalid_r === 1'b1) ? cmd_rdata_r : 16'hxxxx;
  endtask
endmodule

/* File: vout_setpoint_checker.sv */
// Port-level assertions for the setpoint command logic
`timescale 1ns/1ps
module vout_setpoint_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata_r,
  input wire logic cmd_rvalid_r,
  input wire logic invalid_data_r,
  input wire logic max_min_warning_r,
  input wire logic conversion_enabled,
  input wire logic restore_user_all,
  input wire logic [1:0] scale_loop_sel,
  input wire logic [15:0] dac_reference,
  input wire logic reference_settled,
  input wire logic relative_format_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // --------------------------------
  // Helper terms
  // --------------------------------
  logic mode_rd;
  logic mode_wr;
  assign mode_rd = cmd_valid && !cmd_write && cmd_code == 8'h20;
  assign mode_wr = cmd_valid && cmd_write && cmd_code == 8'h20 && !restore_user_all;

  // --------------------------------
  // Assertions
  // --------------------------------
  read_answer_a: assert property (cmd_valid && !cmd_write |=> cmd_rvalid_r)
    else $error("read not answered next cycle");
  answer_cause_a: assert property (cmd_rvalid_r |-> $past(cmd_valid && !cmd_write))
    else $error("read answer without read");
  mode_kind_a: assert property (mode_rd |=> cmd_rdata_r[15:8] == 8'h00 && cmd_rdata_r[6:5] == 2'b00)
    else $error("mode kind bits not zero");
  mode_exp_a: assert property (mode_rd |=> cmd_rdata_r[4:0] >= 5'h14 && cmd_rdata_r[4:0] <= 5'h1C)
    else $error("mode exponent out of range");
  mode_locked_a: assert property (mode_wr && conversion_enabled |=> $stable(relative_format_flag))
    else $error("mode changed while converting");
  rel_flag_a: assert property (mode_wr && !conversion_enabled && cmd_wdata[6:5] == 2'b00
    && cmd_wdata[4:0] >= 5'h14 && cmd_wdata[4:0] <= 5'h1C |=> relative_format_flag == $past(cmd_wdata[7]))
    else $error("relative flag not taken");
  bad_kind_a: assert property (mode_wr && !conversion_enabled && cmd_wdata[6:5] != 2'b00 |=> invalid_data_r)
    else $error("bad mode kind not flagged");
  invalid_cause_a: assert property (invalid_data_r |-> $past(cmd_valid && cmd_write))
    else $error("invalid flag without write");
  warn_cause_a: assert property (max_min_warning_r |-> $past(cmd_valid && cmd_write, 2))
    else $error("warning without write");
  dac_ceiling_a: assert property (scale_loop_sel == 2'b00 && reference_settled |-> dac_reference <= 16'h0B33)
    else $error("reference above converter ceiling");
  c_warn: cover property (max_min_warning_r);
  c_invalid: cover property (invalid_data_r);
  c_rel: cover property ($rose(relative_format_flag));
endmodule

bind vout_setpoint_command_logic vout_setpoint_checker i_chk (.clk(clk), .reset_n(reset_n),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
  .cmd_rdata_r(cmd_rdata_r), .cmd_rvalid_r(cmd_rvalid_r), .invalid_data_r(invalid_data_r),
  .max_min_warning_r(max_min_warning_r), .conversion_enabled(conversion_enabled),
  .restore_user_all(restore_user_all), .scale_loop_sel(scale_loop_sel), .dac_reference(dac_reference),
  .reference_settled(reference_settled), .relative_format_flag(relative_format_flag));

/* File: vout_setpoint_command_logic_test.sv */
// Self-checking testbench for the setpoint command logic
`timescale 1ns/1ps
module vout_setpoint_command_logic_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid, cmd_write, cmd_rvalid_r, invalid_data_r, max_min_warning_r;
  logic [7:0] cmd_code, offset_backup_r;
  logic [15:0] cmd_wdata, cmd_rdata_r, dac_reference;
  logic conv = 1'b0, restore = 1'b0, strap_sel = 1'b0, pin_en = 1'b0, pin_n = 1'b1;
  logic fault = 1'b0, reload = 1'b0, settled, rel_flag;
  logic [15:0] upper = 16'h0B00, lower = 16'h0100;
  logic [1:0] scale = 2'b00;
  int n_fail = 0, total_checks = 0, n_inv = 0, n_warn = 0, cycles = 0, i, w;

  always #12.5 clk = ~clk;

  vout_host_model i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata_r(cmd_rdata_r), .cmd_rvalid_r(cmd_rvalid_r));

  vout_setpoint_command_logic i_dut (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata_r(cmd_rdata_r),
    .cmd_rvalid_r(cmd_rvalid_r), .invalid_data_r(invalid_data_r), .max_min_warning_r(max_min_warning_r),
    .conversion_enabled(conv), .restore_user_all(restore), .nvm_format_mode(8'h14),
    .nvm_setpoint_default(16'h0800), .nvm_offset_backup(8'h00), .strap_override_word(strap_sel),
    .voltage_strap_pin(16'h0600), .reset_pin_enable(pin_en), .powergood_reset_pin_n(pin_n),
    .fault_shutdown(fault), .fault_reload_select(reload), .vout_upper_limit(upper),
    .vout_lower_limit(lower), .scale_loop_sel(scale), .transition_step(16'h0010),
    .offset_backup_r(offset_backup_r), .dac_reference(dac_reference), .reference_settled(settled),
    .relative_format_flag(rel_flag));

  // --------------------------------
  // Pulse counters and hang guard
  // --------------------------------
  always @(posedge clk) begin
    n_inv += (invalid_data_r === 1'b1);
    n_warn += (max_min_warning_r === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] d;
    i_host.rd(code, d);
    check(d, exp);
  endtask

  // Ramp may be long, so poll settled under a bound
  task automatic settle(input logic [15:0] exp);
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (settled !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check(dac_reference, exp);
  endtask

  task automatic pulse_fault();
    @(posedge clk) fault <= 1'b1;
    @(posedge clk) fault <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // --------------------------------
  // Test sequence
  // --------------------------------
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(8'h20, 16'h0014);
    rd_chk(8'h21, 16'h0800);
    settle(16'h0800);
    i_host.wr(8'h21, 16'h0A00);
    rd_chk(8'h21, 16'h0A00);
    settle(16'h0A00);
    $display("test boot and setpoint done");
    // Offset past upper limit, then negative, then outside the valid range
    w = n_warn;
    i_host.wr(8'h22, 16'h0120);
    settle(16'h0B00);
    check(16'(n_warn - w), 16'h0001);
    check({8'h00, offset_backup_r}, 16'h007F);
    i_host.wr(8'h22, 16'hFF00);
    settle(16'h0900);
    check({8'h00, offset_backup_r}, 16'h0080);
    i = n_inv;
    i_host.wr(8'h22, 16'h0200);
    rd_chk(8'h22, 16'hFF00);
    check(16'(n_inv - i), 16'h0001);
    $display("test offset done");
    // Above the converter ceiling but below the limit: silent clamp; below the lower limit: clamp with warning
    i_host.wr(8'h22, 16'h0000);
    upper <= 16'hFFFF;
    w = n_warn;
    i_host.wr(8'h21, 16'h0C00);
    settle(16'h0B33);
    check(16'(n_warn - w), 16'h0000);
    w = n_warn;
    i_host.wr(8'h21, 16'h0080);
    settle(16'h0100);
    check(16'(n_warn - w), 16'h0001);
    scale <= 2'b11;
    i_host.wr(8'h21, 16'h5000);
    settle(16'h5000);
    $display("test clamp done");
    // Boot value survives writes and returns by pin, fault and restore
    pin_en <= 1'b1;
    @(posedge clk) pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    pin_n <= 1'b1;
    rd_chk(8'h21, 16'h0800);
    i_host.wr(8'h21, 16'h0300);
    pulse_fault();
    rd_chk(8'h21, 16'h0300);
    reload <= 1'b1;
    pulse_fault();
    rd_chk(8'h21, 16'h0800);
    strap_sel <= 1'b1;
    @(posedge clk) restore <= 1'b1;
    @(posedge clk) restore <= 1'b0;
    rd_chk(8'h21, 16'h0600);
    $display("test boot sources done");
    // Mode change re-expresses stored words; bad and locked writes refused
    i_host.wr(8'h20, 16'h0018);
    rd_chk(8'h20, 16'h0018);
    rd_chk(8'h21, 16'h0060);
    i_host.wr(8'h21, 16'h0050);
    i = n_inv;
    i_host.wr(8'h20, 16'h0060);
    i_host.wr(8'h20, 16'h001D);
    rd_chk(8'h20, 16'h0018);
    check(16'(n_inv - i), 16'h0002);
    conv <= 1'b1;
    i_host.wr(8'h20, 16'h0094);
    rd_chk(8'h20, 16'h0018);
    conv <= 1'b0;
    i_host.wr(8'h20, 16'h0094);
    rd_chk(8'h20, 16'h0094);
    check({15'h0000, rel_flag}, 16'h0001);
    rd_chk(8'h21, 16'h0500);
    $display("test mode done");
    report_and_stop();
  end
endmodule
